// ===== common/spc_consts.vh
/*
 * Constants of the serial port block: register indices and byte
 * addresses, field positions, reset values and clock-divider counts.
 * Included by the design module, the checker and the bench; holds definitions only.
 */
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------
`define SPC_IDX_CONTROL 8'h2c
`define SPC_IDX_STATUS 8'h2d
`define SPC_IDX_DATA 8'h2e
`define SPC_ADDR_CONTROL 8'hb0
`define SPC_ADDR_STATUS 8'hb4
`define SPC_ADDR_DATA 8'hb8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPC_CTL_IRQ_EN 7
`define SPC_CTL_ENABLE 6
`define SPC_CTL_BIT_ORDER 5
`define SPC_CTL_ROLE 4
`define SPC_CTL_IDLE_LEVEL 3
`define SPC_CTL_PHASE 2
`define SPC_CTL_RATE_HI 1
`define SPC_CTL_RATE_LO 0
`define SPC_CTL_RESET 8'h00

// ----------------------------------------------------------------
// Status register fields, data register reset value
// ----------------------------------------------------------------
`define SPC_STA_DONE 7
`define SPC_STA_COLLISION 6
`define SPC_STA_DOUBLE 0
`define SPC_STA_RESET 8'h00
`define SPC_DATA_RESET 8'h00

// ----------------------------------------------------------------
// Serial clock half periods in core cycles (divisor / 2), and index of the last clock edge of a byte
// ----------------------------------------------------------------
`define SPC_HALF_DIV4 7'h02
`define SPC_HALF_DIV16 7'h08
`define SPC_HALF_DIV64 7'h20
`define SPC_HALF_DIV128 7'h40
`define SPC_HALF_DIV2 7'h01
`define SPC_HALF_DIV8 7'h04
`define SPC_HALF_DIV32 7'h10
`define SPC_EDGES_LAST 4'hf

`endif

// ===== logic/spc_port.v
/*
 * Byte-wide serial peripheral port, master or slave, with its control,
 * status and data registers on an APB slave.
 * Assumes one 50 MHz core clock, synchronous active-high reset, pin
 * inputs already synchronous to clk, and an external pad that resolves
 * each pin from its active-low output enable.
 */
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "spc_consts.vh"

module spc_port (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire global_irq_enable,
    input wire vector_ack,
    output reg irq_q,
    input wire ss_is_input,
    input wire ss_n_in,
    input wire sck_in,
    output reg sck_out_q,
    output reg sck_oe_n_q,
    input wire mosi_in,
    output reg mosi_out_q,
    output reg mosi_oe_n_q,
    input wire miso_in,
    output reg miso_out_q,
    output reg miso_oe_n_q
);

    reg [7:0] ctl_q;
    reg double_q;
    reg done_flag_q;
    reg coll_flag_q;
    reg arm_done_q;
    reg arm_coll_q;
    reg [7:0] rxbuf_q;
    reg [7:0] sr_q;
    reg [7:0] sr_d;
    reg [3:0] ecnt_q;
    reg [3:0] ecnt_d;
    reg pend_q;
    reg pend_d;
    reg inb_q;
    reg inb_d;
    reg busy_q;
    reg busy_d;
    reg done;
    reg sample;
    reg [6:0] div_q;
    reg [6:0] half;
    reg sck_prev_q;
    reg [7:0] rd_val;
    reg mapped;

    wire en = ctl_q[`SPC_CTL_ENABLE];
    wire master = ctl_q[`SPC_CTL_ROLE];
    wire lsb_first = ctl_q[`SPC_CTL_BIT_ORDER];
    wire clock_sample_phase = ctl_q[`SPC_CTL_PHASE];
    wire clock_idle_level = ctl_q[`SPC_CTL_IDLE_LEVEL];
    wire [1:0] rate = {ctl_q[`SPC_CTL_RATE_HI], ctl_q[`SPC_CTL_RATE_LO]};

    wire acc = psel && penable && pready;
    wire wr_ctl = acc && pwrite && paddr == `SPC_ADDR_CONTROL;
    wire wr_sta = acc && pwrite && paddr == `SPC_ADDR_STATUS;
    wire rd_sta = acc && !pwrite && paddr == `SPC_ADDR_STATUS;
    wire acc_data = acc && paddr == `SPC_ADDR_DATA;
    wire wr_data = acc_data && pwrite;

    // ----------------------------------------------------------------
    // Role, selection and transfer activity
    // ----------------------------------------------------------------
    // master mode fault
    wire fault = en && master && ss_is_input && !ss_n_in;
    wire slave_sel = en && !master && !ss_n_in;
    wire abort = !en || fault || (!master && ss_n_in);
    wire in_progress = master ? busy_q : (ecnt_q != 4'h0 || pend_q);
    wire start = wr_data && !in_progress;
    wire collide = wr_data && in_progress && en;
    wire in_bit = master ? miso_in : mosi_in;

    // ----------------------------------------------------------------
    // Serial clock rate
    // ----------------------------------------------------------------
    always @* begin
        if (double_q) begin
            case (rate)
                2'b00: half = `SPC_HALF_DIV2;
                2'b01: half = `SPC_HALF_DIV8;
                2'b10: half = `SPC_HALF_DIV32;
                default: half = `SPC_HALF_DIV64;
            endcase
        end else begin
            case (rate)
                2'b00: half = `SPC_HALF_DIV4;
                2'b01: half = `SPC_HALF_DIV16;
                2'b10: half = `SPC_HALF_DIV64;
                default: half = `SPC_HALF_DIV128;
            endcase
        end
    end

    // Slave edges need no filter: the far master keeps the clock slow
    // enough that each level lasts at least two core cycles.
    // slave clock edge detect
    wire slave_edge = slave_sel && sck_in != sck_prev_q;
    wire master_edge = en && master && busy_q && div_q == half - 7'h01;
    wire edge_ev = master ? master_edge : slave_edge;

    function [7:0] shift_in;
        input [7:0] v;
        input b;
        input lsb;
        begin
            shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
        end
    endfunction

    // ----------------------------------------------------------------
    // Shift engine, shared by both roles
    // ----------------------------------------------------------------
    always @* begin
        sr_d = sr_q;
        ecnt_d = ecnt_q;
        pend_d = pend_q;
        inb_d = inb_q;
        busy_d = busy_q;
        done = 1'b0;
        sample = 1'b0;
        if (abort) begin
            ecnt_d = 4'h0;
            pend_d = 1'b0;
            busy_d = 1'b0;
        end
        if (start) begin
            sr_d = pwdata[7:0];
            ecnt_d = 4'h0;
            pend_d = 1'b0;
            busy_d = en && master && !fault;
        end else if (edge_ev && !abort) begin
            // even edge count is the leading edge
            sample = ecnt_q[0] == clock_sample_phase;
            if (sample) begin
                if (ecnt_q == `SPC_EDGES_LAST) begin
                    sr_d = shift_in(sr_q, in_bit, lsb_first);
                    done = 1'b1;
                end else begin
                    inb_d = in_bit;
                    pend_d = 1'b1;
                end
            end else if (pend_q) begin
                sr_d = shift_in(sr_q, inb_q, lsb_first);
                pend_d = 1'b0;
                done = ecnt_q == `SPC_EDGES_LAST;
            end
            ecnt_d = ecnt_q + 4'h1;
            if (done) begin
                busy_d = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Shift engine and pin registers
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            sr_q <= `SPC_DATA_RESET;
            ecnt_q <= 4'h0;
            pend_q <= 1'b0;
            inb_q <= 1'b0;
            busy_q <= 1'b0;
            div_q <= 7'h00;
            sck_prev_q <= 1'b0;
            rxbuf_q <= `SPC_DATA_RESET;
            sck_out_q <= 1'b0;
            sck_oe_n_q <= 1'b1;
            mosi_out_q <= 1'b0;
            mosi_oe_n_q <= 1'b1;
            miso_out_q <= 1'b0;
            miso_oe_n_q <= 1'b1;
        end else begin
            sr_q <= sr_d;
            ecnt_q <= ecnt_d;
            pend_q <= pend_d;
            inb_q <= inb_d;
            busy_q <= busy_d;
            sck_prev_q <= sck_in;
            if (start || !busy_q || master_edge) begin
                div_q <= 7'h00;
            end else begin
                div_q <= div_q + 7'h01;
            end
            if (!busy_d) begin
                sck_out_q <= clock_idle_level;
            end else if (master_edge) begin
                sck_out_q <= ~sck_out_q;
            end
            // only finished bytes reach the buffer
            if (done) begin
                rxbuf_q <= sr_d;
            end
            sck_oe_n_q <= !(en && master && !fault);
            mosi_oe_n_q <= !(en && master && !fault);
            miso_oe_n_q <= !slave_sel;
            // data line holds through the closing sample edge
            if (!done) begin
                mosi_out_q <= lsb_first ? sr_d[0] : sr_d[7];
                miso_out_q <= lsb_first ? sr_d[0] : sr_d[7];
            end
        end
    end

    // ----------------------------------------------------------------
    // Register file and flags
    // ----------------------------------------------------------------
    always @* begin
        mapped = 1'b1;
        case (paddr)
            `SPC_ADDR_CONTROL: rd_val = ctl_q;
            `SPC_ADDR_STATUS: rd_val = {done_flag_q, coll_flag_q, 5'h00, double_q};
            `SPC_ADDR_DATA: rd_val = rxbuf_q;
            default: begin
                rd_val = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            ctl_q <= `SPC_CTL_RESET;
            double_q <= 1'b0;
            done_flag_q <= 1'b0;
            coll_flag_q <= 1'b0;
            arm_done_q <= 1'b0;
            arm_coll_q <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // No wait state: answer is prepared during the setup cycle
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata <= {24'h00_0000, rd_val};
                pslverr <= !mapped;
            end
            if (wr_ctl) begin
                ctl_q <= pwdata[7:0];
            end
            if (fault) begin
                ctl_q[`SPC_CTL_ROLE] <= 1'b0;
            end
            if (wr_sta) begin
                double_q <= pwdata[`SPC_STA_DOUBLE];
            end
            // arm on status read showing flags
            if (rd_sta) begin
                arm_done_q <= prdata[`SPC_STA_DONE] | prdata[`SPC_STA_COLLISION];
                arm_coll_q <= prdata[`SPC_STA_COLLISION];
            end else if (acc_data) begin
                arm_done_q <= 1'b0;
                arm_coll_q <= 1'b0;
            end
            if (done || fault) begin
                done_flag_q <= 1'b1;
            end else if (vector_ack || (acc_data && arm_done_q)) begin
                done_flag_q <= 1'b0;
            end
            if (collide) begin
                coll_flag_q <= 1'b1;
            end else if (acc_data && arm_coll_q) begin
                coll_flag_q <= 1'b0;
            end
            irq_q <= done_flag_q && ctl_q[`SPC_CTL_IRQ_EN] && global_irq_enable;
        end
    end

endmodule // spc_port

// ===== test/spc_port_assertions.sv
/* Checker for spc_port: bus answer timing, read data shape, interrupt
   gating and pin release. Bound to every spc_port instance. */
`timescale 1ns/1ns
`include "spc_consts.vh"
module spc_port_assertions (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire global_irq_enable,
    input wire vector_ack,
    input wire irq_q,
    input wire ss_is_input,
    input wire ss_n_in,
    input wire mosi_oe_n_q,
    input wire miso_oe_n_q
);
    wire mapped = paddr == `SPC_ADDR_CONTROL || paddr == `SPC_ADDR_STATUS
        || paddr == `SPC_ADDR_DATA;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable && pready; endsequence
    sequence ss_high_s; ss_n_in ##1 ss_n_in; endsequence
    chk_apb_answer: assert property (setup_s |=> access_s)
        else $error("no answer after setup");
    chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready not a single access pulse");
    chk_err_unmapped: assert property (access_s |-> pslverr == !mapped)
        else $error("error response wrong for address");
    chk_rdata_upper: assert property (access_s |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_status_zero: assert property (
        access_s and !pwrite && paddr == `SPC_ADDR_STATUS |-> prdata[5:1] == 5'h0)
        else $error("unused status bits set");
    chk_irq_gated: assert property (
        !global_irq_enable ##1 !global_irq_enable |-> !irq_q)
        else $error("irq without global enable");
    chk_vector_clear: assert property (vector_ack |-> ##2 !irq_q)
        else $error("irq stays after vector");
    chk_slave_quiet: assert property (ss_high_s |-> miso_oe_n_q)
        else $error("miso driven while deselected");
    chk_fault_release: assert property (
        ss_is_input && !ss_n_in && !mosi_oe_n_q |-> ##[1:3] mosi_oe_n_q)
        else $error("mosi kept after mode fault");
endmodule // spc_port_assertions
bind spc_port spc_port_assertions chk_u (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .global_irq_enable, .vector_ack, .irq_q,
    .ss_is_input, .ss_n_in, .mosi_oe_n_q, .miso_oe_n_q);

// ===== test/spc_port_bench.sv
/* Bench for spc_port: register checks, master transfers in all rates
   against a slave model, collision, mode fault. Needs common/ included. */
`timescale 1ns/1ns
`include "spc_consts.vh"
module spc_port_bench;
    localparam [7:0] A_CT = `SPC_ADDR_CONTROL;
    localparam [7:0] A_ST = `SPC_ADDR_STATUS;
    localparam [7:0] A_DT = `SPC_ADDR_DATA;
    reg clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    reg gie = 0, vack = 0, ss_in = 0, ss_n = 1, clock_idle_level = 0, clock_sample_phase = 0, mosi_drv = 0;
    reg [7:0] paddr = 0, stx = 0;
    reg [31:0] pwdata = 0;
    wire pready, pslverr, irq, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_o, miso_oe_n;
    wire [31:0] prdata;
    wire [7:0] srx;
    int miscompares = 0, n_checks = 0;
    int halves[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
    logic [31:0] rv;
    logic err;
    // A released clock line rests at its idle level
    wire sck_w = sck_oe_n ? clock_idle_level : sck;
    wire mosi_w = mosi_oe_n ? mosi_drv : mosi;
    wire miso_w = miso_oe_n ? miso : miso_o;
    spc_port dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .global_irq_enable(gie), .vector_ack(vack), .irq_q(irq),
        .ss_is_input(ss_in), .ss_n_in(ss_n), .sck_in(sck_w), .sck_out_q(sck),
        .sck_oe_n_q(sck_oe_n), .mosi_in(mosi_w), .mosi_out_q(mosi),
        .mosi_oe_n_q(mosi_oe_n), .miso_in(miso_w), .miso_out_q(miso_o),
        .miso_oe_n_q(miso_oe_n));
    spc_slave_model sm (.clk, .clock_idle_level, .clock_sample_phase, .sck(sck_w), .mosi(mosi_w), .ss_n,
        .tx(stx), .miso, .rx_q(srx));
    initial forever #10 clk = ~clk;
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int k = 0; k < 8; k++) rev[k] = v[7 - k];
    endfunction
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int t;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) miscompares++;
        rv = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task s_regs;
        apb(0, A_CT, 0);
        chk("control reset", rv, `SPC_CTL_RESET);
        apb(0, A_ST, 0);
        chk("status reset", rv, `SPC_STA_RESET);
        apb(0, A_DT, 0);
        chk("data reset", rv, `SPC_DATA_RESET);
        apb(1, A_CT, 8'h2f);
        apb(0, A_CT, 0);
        chk("control rw", rv, 32'h2f);
        apb(1, A_ST, 8'hff);
        apb(0, A_ST, 0);
        chk("status ro", rv, 32'h01);
        apb(0, 8'h00, 0);
        chk("unmapped", {err, rv[30:0]}, 32'h80000000);
        apb(1, A_ST, 0);
    endtask
    // ----------------------------------------------------------------
    // One master byte; i picks rate, speed, mode, order and irq
    // ----------------------------------------------------------------
    task xfer(input logic [2:0] i);
        logic [7:0] ctl, tx;
        int t;
        ctl = {i[2], 1'b1, i[2], 1'b1, i[1] ^ i[2], i[0], i[1:0]};
        tx = 8'h96 + 8'h25 * i;
        clock_idle_level <= ctl[3];
        clock_sample_phase <= ctl[2];
        gie <= i[0];
        stx <= ~tx;
        ss_n <= 1;
        apb(1, A_ST, {7'h0, i[2]});
        apb(1, A_CT, ctl);
        repeat (2) @(posedge clk);
        ss_n <= 0;
        apb(1, A_DT, tx);
        if (i == 3) apb(1, A_DT, 8'h00);
        t = 0;
        while (sck === ctl[3] && t < 300) begin
            @(posedge clk);
            t++;
        end
        t = 0;
        while (sck !== ctl[3] && t < 300) begin
            @(posedge clk);
            t++;
        end
        chk("half period", t, halves[i]);
        t = 0;
        do begin
            apb(0, A_ST, 0);
            t++;
        end while (rv[7] !== 1'b1 && t < 400);
        chk("status", rv, {24'h0, 1'b1, i == 3, 5'h0, i[2]});
        chk("irq", irq, i[2] & i[0]);
        if (i[2] & i[0]) begin
            vack <= 1;
            @(posedge clk);
            vack <= 0;
            apb(0, A_ST, 0);
            chk("vector clear", rv, i[2]);
        end
        apb(0, A_DT, 0);
        chk("rx byte", rv, i[2] ? rev(stx) : stx);
        chk("model rx", srx, i[2] ? rev(tx) : tx);
        apb(0, A_ST, 0);
        chk("flags clear", rv, i[2]);
        chk("idle level", sck, ctl[3]);
    endtask
    task s_fault;
        apb(1, A_ST, 0);
        apb(1, A_CT, 8'h50);
        ss_in <= 1;
        repeat (4) @(posedge clk);
        apb(0, A_CT, 0);
        chk("fault role", rv, 32'h40);
        apb(0, A_ST, 0);
        chk("fault flag", rv, 32'h80);
        apb(0, A_DT, 0);
        apb(0, A_ST, 0);
        chk("fault clear", rv, 0);
        ss_in <= 0;
    endtask
    task s_disabled;
        ss_n <= 1;
        apb(1, A_CT, 8'h10);
        apb(1, A_DT, 8'h5a);
        repeat (50) @(posedge clk);
        apb(0, A_ST, 0);
        chk("disabled", {mosi_oe_n, rv[30:0]}, 32'h80000000);
    endtask
    // ----------------------------------------------------------------
    // Slave byte in mode 0, the bench acting as the far master
    // ----------------------------------------------------------------
    task s_slave;
        logic [7:0] rx_b, tx_b, seen;
        rx_b = 8'h3c;
        tx_b = 8'ha5;
        seen = 8'h00;
        clock_idle_level <= 0;
        ss_n <= 1;
        apb(1, A_CT, 8'h40);
        apb(1, A_DT, tx_b);
        ss_n <= 0;
        repeat (2) @(posedge clk);
        for (int k = 7; k >= 0; k--) begin
            // each clock level lasts two core cycles
            mosi_drv <= rx_b[k];
            repeat (2) @(posedge clk);
            seen[k] = miso_w;
            clock_idle_level <= 1;
            repeat (2) @(posedge clk);
            clock_idle_level <= 0;
        end
        repeat (4) @(posedge clk);
        chk("slave miso", seen, tx_b);
        apb(0, A_ST, 0);
        chk("slave done", rv, 32'h80);
        apb(0, A_DT, 0);
        chk("slave rx", rv, rx_b);
        apb(0, A_ST, 0);
        chk("slave clear", rv, 0);
        ss_n <= 1;
    endtask
    task conclude;
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        s_regs;
        for (int i = 0; i < 8; i++) xfer(i[2:0]);
        s_fault;
        s_disabled;
        s_slave;
        conclude;
    end
    // Whole run needs about 3000 cycles; this allows over six times that
    initial begin
        #400000;
        miscompares++;
        conclude;
    end
endmodule // spc_port_bench

// ===== test/spc_slave_model.sv
/* Slave device model for the port's master transfers.
   Assumes sck and mosi are resolved pin levels and ss_n selects it. */
`timescale 1ns/1ns
module spc_slave_model (
    input wire clk,
    input wire clock_idle_level,
    input wire clock_sample_phase,
    input wire sck,
    input wire mosi,
    input wire ss_n,
    input wire [7:0] tx,
    output wire miso,
    output reg [7:0] rx_q
);
    reg [7:0] sh_q;
    reg first_q;
    // Deselected line shows the inverse so a stale bit never passes
    assign miso = ss_n ? ~sh_q[7] : sh_q[7];
    always @(posedge clk) begin
        if (ss_n) begin
            sh_q <= tx;
            first_q <= 1'b1;
        end
    end
    always @(sck) begin
        if (!ss_n) begin
            if ((sck != clock_idle_level) ^ clock_sample_phase)
                rx_q <= {rx_q[6:0], mosi};
            else if (first_q && clock_sample_phase)
                first_q <= 1'b0;
            else
                sh_q <= {sh_q[6:0], 1'b0};
        end
    end
endmodule // spc_slave_model
